// ==== verilog/qfs_sequencer.sv ====
// Purpose: Control and protection sequencer of a quasi-resonant flyback controller
// Assumes: Comparator levels on pins, 10 MHz mclk, variant strap stable at reset
// Notes: Gate on-time ends on cs_trip; peak_limit feeds the current comparator
`timescale 1ns/1ps
module qfs_sequencer #(
    parameter int SOFT_START_CYC = qfs_pkg::SOFT_START_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic demag_cmp,
    input wire logic overvoltage_cmp,
    input wire logic ext_latch_req,
    input wire logic feedback_input_grounded,
    input wire logic feedback_input_at_max,
    input wire logic vcc_above_off,
    input wire logic vcc_above_on,
    input wire logic vcc_above_latchoff,
    input wire logic vcc_above_reset,
    input wire logic cs_trip,
    input wire logic skip_ok,
    input wire logic variant_b,
    output logic gate_drive,
    output logic self_supply_source,
    output logic standby_supply_current,
    output logic [7:0] peak_limit,
    output logic overvoltage_trip,
    output logic ext_latched,
    output logic overcurrent_fault_cycle
);
    localparam int SS_STEP_INT = (SOFT_START_CYC / 255 < 1) ? 1 : SOFT_START_CYC / 255;
    localparam logic [15:0] SS_STEP = 16'(SS_STEP_INT);
    logic [qfs_pkg::NUM_IN-1:0] raw;
    logic [qfs_pkg::NUM_IN-1:0] sy;
    qfs_pkg::qfs_state_e state;
    qfs_pkg::qfs_state_e next_state;
    logic s_demag, s_ovp, s_latch_req, s_fb_low, s_fb_max, s_vcc_off, s_vcc_on, s_vcc_latch, s_vcc_reset, s_cs, s_skip;
    logic demag_prev, vcc_off_prev, vcc_on_prev, demag_evt, vcc_off_fall, vcc_on_fall;
    logic [1:0] strap_cnt;
    logic var_b;
    logic [7:0] min_off_cyc, smp_cyc, off_cnt, tmo_cnt;
    logic min_off_done, tmo_done, demag_seen, ovp_hit, latch_evt, ol_armed, pulse_en, start_ok;
    logic [15:0] ss_div;

    // Pin levels into the synchroniser
    assign raw[qfs_pkg::IN_DEMAG] = demag_cmp;
    assign raw[qfs_pkg::IN_OVP] = overvoltage_cmp;
    assign raw[qfs_pkg::IN_LATCH] = ext_latch_req;
    assign raw[qfs_pkg::IN_FB_LOW] = feedback_input_grounded;
    assign raw[qfs_pkg::IN_FB_MAX] = feedback_input_at_max;
    assign raw[qfs_pkg::IN_VCC_OFF] = vcc_above_off;
    assign raw[qfs_pkg::IN_VCC_ON] = vcc_above_on;
    assign raw[qfs_pkg::IN_VCC_LATCH] = vcc_above_latchoff;
    assign raw[qfs_pkg::IN_VCC_RESET] = vcc_above_reset;
    assign raw[qfs_pkg::IN_CS] = cs_trip;
    assign raw[qfs_pkg::IN_SKIP] = skip_ok;
    assign raw[qfs_pkg::IN_VARIANT] = variant_b;

    qfs_sync u_sync (.mclk(mclk), .rst_b(rst_b), .d(raw), .q(sy));

    assign s_demag = sy[qfs_pkg::IN_DEMAG];
    assign s_ovp = sy[qfs_pkg::IN_OVP];
    assign s_latch_req = sy[qfs_pkg::IN_LATCH];
    assign s_fb_low = sy[qfs_pkg::IN_FB_LOW];
    assign s_fb_max = sy[qfs_pkg::IN_FB_MAX];
    assign s_vcc_off = sy[qfs_pkg::IN_VCC_OFF];
    assign s_vcc_on = sy[qfs_pkg::IN_VCC_ON];
    assign s_vcc_latch = sy[qfs_pkg::IN_VCC_LATCH];
    assign s_vcc_reset = sy[qfs_pkg::IN_VCC_RESET];
    assign s_cs = sy[qfs_pkg::IN_CS];
    assign s_skip = sy[qfs_pkg::IN_SKIP];

    // Edge detection on synchronised levels
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            demag_prev <= 1'b0;
            vcc_off_prev <= 1'b0;
            vcc_on_prev <= 1'b0;
        end else begin
            demag_prev <= s_demag;
            vcc_off_prev <= s_vcc_off;
            vcc_on_prev <= s_vcc_on;
        end
    end

    assign demag_evt = demag_prev & ~s_demag;
    assign vcc_off_fall = vcc_off_prev & ~s_vcc_off;
    assign vcc_on_fall = vcc_on_prev & ~s_vcc_on;
    // Variant strap caught once the synchroniser has filled
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt <= 2'h0;
            var_b <= 1'b0;
        end else if (strap_cnt != 2'h3) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == 2'h2) begin
                var_b <= sy[qfs_pkg::IN_VARIANT];
            end
        end
    end

    assign min_off_cyc = var_b ? qfs_pkg::MIN_OFF_B_CYC : qfs_pkg::MIN_OFF_A_CYC;
    assign smp_cyc = var_b ? qfs_pkg::OVP_SMP_B_CYC : qfs_pkg::OVP_SMP_A_CYC;

    // Cycles since turn-off, saturating
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            off_cnt <= qfs_pkg::CNT_RST;
        end else if (gate_drive) begin
            off_cnt <= qfs_pkg::CNT_RST;
        end else if (off_cnt != qfs_pkg::CNT_SAT) begin
            off_cnt <= off_cnt + 8'h01;
        end
    end

    assign min_off_done = !gate_drive && (off_cnt >= min_off_cyc - 8'h01);
    assign ovp_hit = (state == qfs_pkg::ST_RUN) && !gate_drive
        && (off_cnt == smp_cyc - 8'h01) && s_ovp;
    assign latch_evt = ovp_hit || s_latch_req;

    // Restart timeout, cleared by every falling demag crossing
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tmo_cnt <= qfs_pkg::CNT_RST;
        end else if (gate_drive || demag_evt) begin
            tmo_cnt <= qfs_pkg::CNT_RST;
        end else if (tmo_cnt != qfs_pkg::RESTART_TMO_CYC) begin
            tmo_cnt <= tmo_cnt + 8'h01;
        end
    end

    assign tmo_done = (tmo_cnt == qfs_pkg::RESTART_TMO_CYC);
    // Demag seen after blanking; a new event wins over the clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            demag_seen <= 1'b0;
        end else if (demag_evt && min_off_done) begin
            demag_seen <= 1'b1;
        end else if (gate_drive) begin
            demag_seen <= 1'b0;
        end
    end

    assign pulse_en = (state == qfs_pkg::ST_RUN) && !s_fb_low && !latch_evt;
    assign start_ok = pulse_en && !gate_drive && min_off_done
        && (demag_seen || tmo_done) && s_skip;

    // Gate drive
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gate_drive <= 1'b0;
        end else if (!pulse_en) begin
            gate_drive <= 1'b0;
        end else if (gate_drive && s_cs) begin
            gate_drive <= 1'b0;
        end else if (start_ok) begin
            gate_drive <= 1'b1;
        end
    end

    // Overload watch armed as the rail falls from the upper threshold
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ol_armed <= 1'b0;
        end else if (state != qfs_pkg::ST_RUN || vcc_on_fall) begin
            ol_armed <= 1'b0;
        end else if (vcc_off_fall) begin
            ol_armed <= 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            qfs_pkg::ST_POWER_UP: begin
                if (s_vcc_off) begin
                    next_state = qfs_pkg::ST_RUN;
                end
            end
            qfs_pkg::ST_RUN: begin
                if (vcc_on_fall && ol_armed && s_fb_max) begin
                    next_state = qfs_pkg::ST_STANDBY;
                end
            end
            qfs_pkg::ST_STANDBY: begin
                if (!s_vcc_latch) begin
                    next_state = qfs_pkg::ST_RESTART;
                end
            end
            qfs_pkg::ST_RESTART: begin
                if (s_vcc_off) begin
                    next_state = qfs_pkg::ST_RUN;
                end
            end
            qfs_pkg::ST_LATCHED: begin
                next_state = qfs_pkg::ST_LATCHED;
            end
            default: begin
                next_state = qfs_pkg::ST_POWER_UP;
            end
        endcase
        if (latch_evt) begin
            next_state = qfs_pkg::ST_LATCHED;
        end
        if (!s_vcc_reset) begin
            next_state = qfs_pkg::ST_POWER_UP;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= qfs_pkg::ST_POWER_UP;
        end else begin
            state <= next_state;
        end
    end

    // Fault flags, cleared only by the rail dropping below reset level
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            overvoltage_trip <= 1'b0;
            ext_latched <= 1'b0;
        end else if (!s_vcc_reset) begin
            overvoltage_trip <= 1'b0;
            ext_latched <= 1'b0;
        end else begin
            if (ovp_hit) begin
                overvoltage_trip <= 1'b1;
            end
            if (s_latch_req) begin
                ext_latched <= 1'b1;
            end
        end
    end

    // Self-supply source control
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            self_supply_source <= 1'b1;
        end else begin
            case (next_state)
                qfs_pkg::ST_POWER_UP, qfs_pkg::ST_RESTART: begin
                    self_supply_source <= 1'b1;
                end
                qfs_pkg::ST_RUN: begin
                    if (!s_vcc_on) begin
                        self_supply_source <= 1'b1;
                    end else if (s_vcc_off) begin
                        self_supply_source <= 1'b0;
                    end
                end
                qfs_pkg::ST_STANDBY: begin
                    self_supply_source <= 1'b0;
                end
                qfs_pkg::ST_LATCHED: begin
                    if (!s_vcc_latch) begin
                        self_supply_source <= 1'b1;
                    end else if (s_vcc_off) begin
                        self_supply_source <= 1'b0;
                    end
                end
                default: begin
                    self_supply_source <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            standby_supply_current <= 1'b0;
            overcurrent_fault_cycle <= 1'b0;
        end else begin
            standby_supply_current <= (next_state == qfs_pkg::ST_STANDBY);
            overcurrent_fault_cycle <= (next_state == qfs_pkg::ST_STANDBY)
                || (next_state == qfs_pkg::ST_RESTART);
        end
    end

    // Soft-start ramp, restarted on every entry to run
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            peak_limit <= qfs_pkg::PEAK_RST;
            ss_div <= 16'h0000;
        end else if (state != qfs_pkg::ST_RUN) begin
            peak_limit <= qfs_pkg::PEAK_RST;
            ss_div <= 16'h0000;
        end else if (peak_limit != qfs_pkg::PEAK_MAX) begin
            if (ss_div == SS_STEP - 16'h0001) begin
                ss_div <= 16'h0000;
                peak_limit <= peak_limit + 8'h01;
            end else begin
                ss_div <= ss_div + 16'h0001;
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence run_entry;
        (state != qfs_pkg::ST_RUN) ##1 (state == qfs_pkg::ST_RUN);
    endsequence
    sequence latched_then(logic flag);
        (state == qfs_pkg::ST_LATCHED) ##1 flag;
    endsequence
    chk_min_off_gap:
    assert property ($rose(gate_drive) |-> $past(off_cnt) >= $past(min_off_cyc) - 8'h01)
        else $error("gate rose inside minimum off-time");
    chk_ovp_sample_latch:
    assert property ((s_ovp && !gate_drive && state == qfs_pkg::ST_RUN && s_vcc_reset
        && off_cnt == smp_cyc - 8'h01) |=> latched_then(overvoltage_trip))
        else $error("overvoltage sample did not latch");
    chk_latch_no_gate:
    assert property ((state == qfs_pkg::ST_LATCHED) |-> !gate_drive)
        else $error("gate active while latched");
    chk_latch_supply_on:
    assert property ((state == qfs_pkg::ST_LATCHED && !s_vcc_latch && s_vcc_reset)
        |=> self_supply_source)
        else $error("self supply off below latchoff level");
    chk_latch_release:
    assert property ((state == qfs_pkg::ST_LATCHED && !s_vcc_reset)
        |=> (state == qfs_pkg::ST_POWER_UP) ##1 !overvoltage_trip && !ext_latched)
        else $error("latch not released at reset level");
    chk_ext_latch_off:
    assert property ((s_latch_req && s_vcc_reset) |=> latched_then(ext_latched))
        else $error("external latch request ignored");
    chk_fb_ground_block:
    assert property (s_fb_low |=> !gate_drive)
        else $error("gate active with feedback grounded");
    chk_overload_standby:
    assert property ((state == qfs_pkg::ST_RUN && vcc_on_fall && ol_armed && s_fb_max
        && !latch_evt && s_vcc_reset) |=> (state == qfs_pkg::ST_STANDBY)
        ##1 (!self_supply_source && standby_supply_current))
        else $error("overload did not enter standby");
    chk_standby_restart:
    assert property ((state == qfs_pkg::ST_STANDBY && !s_vcc_latch && s_vcc_reset
        && !s_latch_req) |=> (state == qfs_pkg::ST_RESTART) ##1 self_supply_source)
        else $error("standby did not restart supply");
    chk_soft_start_zero:
    assert property (run_entry |-> peak_limit == qfs_pkg::PEAK_RST
        ##1 peak_limit == qfs_pkg::PEAK_RST)
        else $error("soft-start did not begin from zero");
    chk_start_cause:
    assert property ($rose(gate_drive) |-> $past(state == qfs_pkg::ST_RUN && s_skip
        && (demag_seen || tmo_done)))
        else $error("gate started without demag or timeout");
endmodule

// ==== verilog/qfs_pkg.sv ====
// Purpose: Shared constants and types for the flyback fault sequencer
// Assumes: 10 MHz mclk; analog thresholds arrive as comparator levels
// Notes: Times in ns, cycle counts derived from them
package qfs_pkg;
    localparam int CLK_NS = 100;

    function automatic int cyc_ceil(input int ns);
        cyc_ceil = (ns + CLK_NS - 1) / CLK_NS;
        if (cyc_ceil < 1) begin
            cyc_ceil = 1;
        end
    endfunction

    // Analog levels handled by the external comparators
    localparam int DEMAG_LEVEL_MV = 50;
    localparam int OVP_REF_MV = 5000;
    localparam int OVP_PIN_MV = 7200;
    localparam int VCC_OFF_MV = 12000;
    localparam int VCC_ON_MV = 10000;
    localparam int VCC_LATCHOFF_MV = 5300;
    localparam int VCC_RESET_MV = 4000;
    localparam int FB_MAX_MV = 4200;

    localparam int MIN_OFF_A_NS = 8000;
    localparam int MIN_OFF_B_NS = 4500;
    localparam int OVP_SMP_A_NS = 4500;
    localparam int OVP_SMP_B_NS = 1500;
    localparam int RESTART_TMO_NS = 5000;
    localparam int SOFT_START_NS = 1000000;

    localparam logic [7:0] MIN_OFF_A_CYC = 8'(cyc_ceil(MIN_OFF_A_NS));
    localparam logic [7:0] MIN_OFF_B_CYC = 8'(cyc_ceil(MIN_OFF_B_NS));
    localparam logic [7:0] OVP_SMP_A_CYC = 8'(cyc_ceil(OVP_SMP_A_NS));
    localparam logic [7:0] OVP_SMP_B_CYC = 8'(cyc_ceil(OVP_SMP_B_NS));
    localparam logic [7:0] RESTART_TMO_CYC = 8'(cyc_ceil(RESTART_TMO_NS));
    localparam int SOFT_START_CYC = cyc_ceil(SOFT_START_NS);

    localparam logic [7:0] PEAK_MAX = 8'hff;
    localparam logic [7:0] PEAK_RST = 8'h00;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [7:0] CNT_SAT = 8'hff;

    // Bit positions of the synchronised input vector
    localparam int IN_DEMAG = 0;
    localparam int IN_OVP = 1;
    localparam int IN_LATCH = 2;
    localparam int IN_FB_LOW = 3;
    localparam int IN_FB_MAX = 4;
    localparam int IN_VCC_OFF = 5;
    localparam int IN_VCC_ON = 6;
    localparam int IN_VCC_LATCH = 7;
    localparam int IN_VCC_RESET = 8;
    localparam int IN_CS = 9;
    localparam int IN_SKIP = 10;
    localparam int IN_VARIANT = 11;
    localparam int NUM_IN = 12;

    typedef enum logic [4:0] {
        ST_POWER_UP = 5'h01,
        ST_RUN = 5'h02,
        ST_STANDBY = 5'h04,
        ST_RESTART = 5'h08,
        ST_LATCHED = 5'h10
    } qfs_state_e;
endpackage

// ==== verilog/qfs_sync.sv ====
// Purpose: Two-stage synchroniser for all pin-level inputs
// Assumes: Inputs are slow comparator levels
// Notes: Only the second stage is visible outside
`timescale 1ns/1ps
module qfs_sync (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [qfs_pkg::NUM_IN-1:0] d,
    output logic [qfs_pkg::NUM_IN-1:0] q
);
    logic [qfs_pkg::NUM_IN-1:0] meta;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ==== verif/qfs_plant.sv ====
// Purpose: Far-side model: aux winding, switch current sense, overvoltage plateau
// Assumes: Outputs settle just after an mclk edge
// Notes: Counts cycles since the last gate edge it saw
`timescale 1ns/1ps
module qfs_plant (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic gate_drive,
    input wire logic variant_b,
    input wire logic [7:0] on_cyc,
    input wire logic [7:0] ring_cyc,
    input wire logic ovp_en,
    output logic demag_cmp,
    output logic cs_trip,
    output logic overvoltage_cmp
);
    logic gate_q;
    logic [7:0] cnt;
    logic [7:0] smp;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gate_q <= 1'b0;
            cnt <= 8'h00;
        end else begin
            gate_q <= gate_drive;
            if (gate_drive != gate_q) begin
                cnt <= 8'h00;
            end else if (cnt != 8'hff) begin
                cnt <= cnt + 8'h01;
            end
        end
    end

    assign smp = variant_b ? qfs_pkg::OVP_SMP_B_CYC : qfs_pkg::OVP_SMP_A_CYC;
    // Plateau after turn-off, falls once the core has reset
    assign demag_cmp = !gate_q && cnt < ring_cyc;
    // Primary current reaches the peak after on_cyc cycles
    assign cs_trip = gate_q && cnt >= on_cyc;
    // Plateau above the trip level only in the ten cycles before the sampling point
    assign overvoltage_cmp = ovp_en && !gate_q && cnt + 8'h0a >= smp && cnt < smp;
endmodule

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the flyback fault sequencer
// Assumes: qfs_plant stands in for transformer and switch; feedback pins driven by the bench
// Notes: Soft start shortened to 510 cycles; rail given as comparator levels
`timescale 1ns/1ps
module tb_top;
    localparam int SS_CYC = 510;
    logic mclk, rst_b, demag_cmp, overvoltage_cmp, ext_latch_req, feedback_input_grounded;
    logic feedback_input_at_max, vcc_above_off, vcc_above_on, vcc_above_latchoff, vcc_above_reset;
    logic cs_trip, skip_ok, variant_b, gate_drive, self_supply_source, standby_supply_current;
    logic overvoltage_trip, ext_latched, overcurrent_fault_cycle, ovp_en;
    logic [7:0] peak_limit, on_cyc, ring_cyc;
    int bad_count = 0;
    int checked = 0;
    int low_n = 0;
    int rises = 0;
    int exp_seen, mo, exp_off, rg;
    int exp_q[$];

    qfs_sequencer #(.SOFT_START_CYC(SS_CYC)) dut (.mclk(mclk), .rst_b(rst_b), .demag_cmp(demag_cmp),
        .overvoltage_cmp(overvoltage_cmp), .ext_latch_req(ext_latch_req),
        .feedback_input_grounded(feedback_input_grounded), .feedback_input_at_max(feedback_input_at_max),
        .vcc_above_off(vcc_above_off), .vcc_above_on(vcc_above_on), .vcc_above_latchoff(vcc_above_latchoff),
        .vcc_above_reset(vcc_above_reset), .cs_trip(cs_trip), .skip_ok(skip_ok), .variant_b(variant_b),
        .gate_drive(gate_drive), .self_supply_source(self_supply_source),
        .standby_supply_current(standby_supply_current), .peak_limit(peak_limit),
        .overvoltage_trip(overvoltage_trip), .ext_latched(ext_latched),
        .overcurrent_fault_cycle(overcurrent_fault_cycle));

    qfs_plant plant (.mclk(mclk), .rst_b(rst_b), .gate_drive(gate_drive), .variant_b(variant_b),
        .on_cyc(on_cyc), .ring_cyc(ring_cyc), .ovp_en(ovp_en), .demag_cmp(demag_cmp), .cs_trip(cs_trip),
        .overvoltage_cmp(overvoltage_cmp));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
            bad_count++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    function automatic logic obs(input int sel);
        case (sel)
            0: return gate_drive;
            1: return overvoltage_trip;
            default: return peak_limit === qfs_pkg::PEAK_MAX;
        endcase
    endfunction

    task automatic wait_obs(input int sel, input logic val, input int lim);
        int n;
        n = 0;
        while (obs(sel) !== val && n < lim) begin
            tick(1);
            n++;
        end
        if (obs(sel) !== val) begin
            $display("wrong value wait %0d expected %0b seen %0b", sel, val, obs(sel));
            bad_count++;
            stop_test();
        end
    endtask

    task automatic no_pulse(input int n);
        int r0;
        tick(4);
        r0 = rises;
        tick(n);
        check("pulses", 32'(rises - r0), 32'h0);
    endtask

    task automatic set_rail(input int mv);
        @(posedge mclk);
        vcc_above_off <= mv >= qfs_pkg::VCC_OFF_MV;
        vcc_above_on <= mv >= qfs_pkg::VCC_ON_MV;
        vcc_above_latchoff <= mv >= qfs_pkg::VCC_LATCHOFF_MV;
        vcc_above_reset <= mv >= qfs_pkg::VCC_RESET_MV;
        tick(6);
    endtask

    // Off-time measured between gate pulses, compared with the oldest note
    always @(negedge mclk) begin
        if (gate_drive === 1'b1) begin
            if (low_n > 0 && exp_q.size() > 0) begin
                exp_seen = exp_q.pop_front();
                check("off time", 32'(low_n >= exp_seen && low_n <= exp_seen + 4), 32'h1);
            end
            if (low_n > 0) begin
                rises++;
            end
            low_n = 0;
        end else begin
            low_n++;
        end
    end

    initial begin
        rst_b = 1'b0;
        ext_latch_req = 1'b0;
        feedback_input_grounded = 1'b0;
        feedback_input_at_max = 1'b0;
        {vcc_above_off, vcc_above_on, vcc_above_latchoff, vcc_above_reset} = 4'h0;
        skip_ok = 1'b1;
        variant_b = 1'b0;
        on_cyc = 8'h08;
        ring_cyc = 8'hff;
        ovp_en = 1'b0;
        void'($urandom(32'h475d5e5e));
        for (int v = 0; v < 2; v++) begin
            mo = v ? int'(qfs_pkg::MIN_OFF_B_CYC) : int'(qfs_pkg::MIN_OFF_A_CYC);
            exp_off = mo > int'(qfs_pkg::RESTART_TMO_CYC) ? mo : int'(qfs_pkg::RESTART_TMO_CYC);
            @(posedge mclk);
            rst_b <= 1'b0;
            variant_b <= v[0];
            {vcc_above_off, vcc_above_on, vcc_above_latchoff, vcc_above_reset} <= 4'h7;
            repeat (2) @(posedge mclk);
            rst_b <= 1'b1;
            tick(1);
            check("reset outs", 32'({gate_drive, self_supply_source, standby_supply_current, peak_limit,
                overvoltage_trip, ext_latched, overcurrent_fault_cycle}), 32'h1000);
            no_pulse(100);
            set_rail(12500);
            tick(100);
            check("ramp mid", 32'(peak_limit > 8'h00 && peak_limit < 8'hff), 32'h1);
            check("source high rail", 32'(self_supply_source), 32'h0);
            wait_obs(2, 1'b1, SS_CYC);
            for (int i = 0; i < 4; i++) begin
                wait_obs(0, 1'b1, 300);
                rg = (i < 3) ? 255 : int'($urandom_range(40, 30));
                @(posedge mclk);
                exp_q.push_back((i < 3) ? exp_off : rg + 3 + int'(qfs_pkg::RESTART_TMO_CYC));
                on_cyc <= 8'($urandom_range(30, 4));
                ring_cyc <= 8'(rg);
                wait_obs(0, 1'b0, 100);
            end
            wait_obs(0, 1'b1, 300);
            tick(1);
            check("notes left", 32'(exp_q.size()), 32'h0);
            @(posedge mclk);
            feedback_input_grounded <= 1'b1;
            ring_cyc <= 8'hff;
            no_pulse($urandom_range(300, 100));
            @(posedge mclk);
            feedback_input_grounded <= 1'b0;
            wait_obs(0, 1'b1, 300);
            @(posedge mclk);
            skip_ok <= 1'b0;
            no_pulse(150);
            @(posedge mclk);
            skip_ok <= 1'b1;
            set_rail(11000);
            check("source held off", 32'(self_supply_source), 32'h0);
            set_rail(9500);
            check("no overload", 32'({self_supply_source, standby_supply_current}), 32'h2);
            wait_obs(0, 1'b1, 300);
            set_rail(12500);
            @(posedge mclk);
            feedback_input_at_max <= 1'b1;
            set_rail(11000);
            set_rail(9500);
            check("standby", 32'({self_supply_source, standby_supply_current, overcurrent_fault_cycle}),
                32'h3);
            no_pulse(100);
            set_rail(5000);
            check("restart source", 32'({self_supply_source, overcurrent_fault_cycle}), 32'h3);
            no_pulse(50);
            @(posedge mclk);
            feedback_input_at_max <= 1'b0;
            set_rail(12500);
            check("ramp again", 32'(peak_limit < 8'h10), 32'h1);
            wait_obs(0, 1'b1, 300);
            check("standby gone", 32'(standby_supply_current), 32'h0);
            @(posedge mclk);
            ovp_en <= 1'b1;
            wait_obs(1, 1'b1, 400);
            @(posedge mclk);
            ovp_en <= 1'b0;
            no_pulse(100);
            check("latched source hi", 32'(self_supply_source), 32'h0);
            set_rail(5000);
            check("latched source lo", 32'(self_supply_source), 32'h1);
            set_rail(4500);
            check("latch kept", 32'(overvoltage_trip), 32'h1);
            set_rail(3000);
            check("latch cleared", 32'(overvoltage_trip), 32'h0);
            set_rail(12500);
            wait_obs(0, 1'b1, SS_CYC + 300);
            @(posedge mclk);
            ext_latch_req <= 1'b1;
            tick(6);
            @(posedge mclk);
            ext_latch_req <= 1'b0;
            no_pulse(100);
            check("ext latch", 32'(ext_latched), 32'h1);
            set_rail(3000);
            check("ext cleared", 32'(ext_latched), 32'h0);
        end
        stop_test();
    end
endmodule
